// File: lpcg_defines.vh
// Purpose: constants for the low-power clock gating bank 0 block
// Assumes: 32-bit register port, byte addresses
// Notes: header only, no logic
`ifndef LPCG_DEFINES_VH
`define LPCG_DEFINES_VH
`define LPCG_RUN_OFF 12'h100
`define LPCG_SLEEP_OFF 12'h110
`define LPCG_DEEP_OFF 12'h120
`define LPCG_CFG_OFF 12'h060
`define LPCG_PSTATE_OFF 12'h130
`define LPCG_IRQ_STAT_OFF 12'h140
`define LPCG_IRQ_MASK_OFF 12'h144
`define LPCG_GATE_RESET 32'h00000040
`define LPCG_GATE_WMASK 32'h00010F08
`define LPCG_ADC_BIT 16
`define LPCG_WDT_BIT 3
`define LPCG_SPD_LSB 8
`define LPCG_SPD_MSB 11
`define LPCG_AUTO_GATE_BIT 27
`define LPCG_CFG_WMASK 32'h08000000
`define LPCG_CFG_RESET 32'h00000000
`define LPCG_PS_RUN 2'h0
`define LPCG_PS_SLEEP 2'h1
`define LPCG_PS_DEEP 2'h2
`define LPCG_IRQ_ADC_FAULT 0
`define LPCG_IRQ_WDT_FAULT 1
`endif

// File: lpcg_gate_sel.v
// Purpose: pick the gating word that applies in the present power state
// Assumes: all inputs on the system clock, power state already synchronised
// Notes: combinational only; the top registers the result
`timescale 1ns/1ps
`include "lpcg_defines.vh"
module lpcg_gate_sel
(
    input wire [31:0] i_run_gate,
    input wire [31:0] i_sleep_gate,
    input wire [31:0] i_deep_gate,
    input wire i_auto_gate,
    input wire [1:0] i_pstate,
    output reg [31:0] o_gate
);
    // without auto gating the run word rules every state
    always @*
    begin
        o_gate = i_run_gate;
        if (i_auto_gate)
        begin
            case (i_pstate)
                `LPCG_PS_SLEEP: o_gate = i_sleep_gate;
                `LPCG_PS_DEEP: o_gate = i_deep_gate;
                default: o_gate = i_run_gate;
            endcase
        end
        else
        begin
            o_gate = i_run_gate;
        end
    end
endmodule // lpcg_gate_sel

// File: lpcg_top.v
// Summary of operation
// - a gating bit of one clocks its peripheral, a zero leaves it unclocked and disabled.
// - any access to a peripheral whose clock is off is answered with a bus fault.
// - gating enable bits leave reset at zero so gated peripherals start unclocked.
// - separate run, sleep and deep-sleep gating registers are kept for the bank.
// - sleep and deep-sleep words apply only while auto clock gating is set.
// - bit 16 of each gating register is read-write and gates converter module 0.
// - bit 3 of each gating register is read-write and gates the watchdog.
// - bits 11 to 8 pick the converter rate: 2 is 500K, 1 is 250K, 0 is 125K samples/s.
// - reserved bits read zero, except bit 6 which reads one until the first write; software keeps them on read-modify-write.
//
// Purpose: clock gating control for converter and watchdog in run, sleep, deep sleep
// Assumes: one 50 MHz clock, register port with read data one cycle after strobe
//          access flags come from the bus decoder on this same clock
// Notes: the power state arrives from outside and is synchronised here
//        a one-cycle glitch on the power state pin never reaches the enables
//        the rate code is not limited in hardware; keeping it legal is software's job
//        bus faults pulse one cycle after the access and also latch a status bit
//        bit 6 of each gating word shows its reset value until the first write
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "lpcg_defines.vh"
module lpcg_top
(
    input wire i_clk,
    input wire i_reset_n,
    input wire [11:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    input wire [1:0] i_pstate,
    input wire i_adc_access,
    input wire i_wdt_access,
    output reg o_adc_clk_en,
    output reg o_wdt_clk_en,
    output reg [3:0] o_converter_sample_speed,
    output reg o_adc_fault,
    output reg o_wdt_fault,
    output reg o_irq
);
    // gating words are indexed by power state and held in flip-flops
    localparam GW_RUN = 0;
    localparam GW_SLEEP = 1;
    localparam GW_DEEP = 2;
    localparam GW_COUNT = 3;
    localparam UNIT_COUNT = 2;

    // control and status state
    reg [31:0] gate_word_r [0:GW_COUNT-1];
    reg [31:0] cfg_r;
    reg [1:0] irq_stat_r;
    reg [1:0] irq_mask_r;
    reg [1:0] ps_s1_r;
    reg [1:0] ps_s2_r;
    reg [1:0] ps_s3_r;
    reg [1:0] pstate_r;
    wire [31:0] gate_sel;
    wire [1:0] fault_ev;
    wire [31:0] wdata_m;
    reg [31:0] rdata_nxt;

    // decoded strobes and per-unit views of the access and enable signals
    wire [GW_COUNT-1:0] wr_gate;
    wire wr_cfg;
    wire wr_stat;
    wire wr_mask;
    wire [UNIT_COUNT-1:0] unit_access;
    wire [UNIT_COUNT-1:0] unit_clk_en;
    genvar g;

    // one address compare shared by every write strobe and the read mux
    function addr_hit;
        input [11:0] addr;
        input [11:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // byte offset of the gating word for one power state index
    function [11:0] gate_offset;
        input integer idx;
        begin
            case (idx)
                GW_RUN: gate_offset = `LPCG_RUN_OFF;
                GW_SLEEP: gate_offset = `LPCG_SLEEP_OFF;
                default: gate_offset = `LPCG_DEEP_OFF;
            endcase
        end
    endfunction

    // write strobes decoded once; an unmapped write hits none of them
    assign wr_cfg = i_wr & addr_hit(i_addr, `LPCG_CFG_OFF);
    assign wr_stat = i_wr & addr_hit(i_addr, `LPCG_IRQ_STAT_OFF);
    assign wr_mask = i_wr & addr_hit(i_addr, `LPCG_IRQ_MASK_OFF);

    // writable bits only; a write never stores a one in a reserved bit
    assign wdata_m = i_wdata & `LPCG_GATE_WMASK;

    // gating registers, one per power state, all built alike
    generate
        for (g = 0; g < GW_COUNT; g = g + 1)
        begin : g_gate
            assign wr_gate[g] = i_wr & addr_hit(i_addr, gate_offset(g));
            // reset value and write path are the same for every word
            always @(posedge i_clk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    gate_word_r[g] <= `LPCG_GATE_RESET;
                end
                else if (wr_gate[g])
                begin
                    gate_word_r[g] <= wdata_m;
                end
            end
        end
    endgenerate

    // run clock configuration: only the auto gating bit is kept
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cfg_r <= `LPCG_CFG_RESET;
        end
        else if (wr_cfg)
        begin
            cfg_r <= i_wdata & `LPCG_CFG_WMASK;
        end
    end

    // power state pin: three stages, accept a change when stages two and three agree
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ps_s1_r <= `LPCG_PS_RUN;
            ps_s2_r <= `LPCG_PS_RUN;
            ps_s3_r <= `LPCG_PS_RUN;
            pstate_r <= `LPCG_PS_RUN;
        end
        else
        begin
            ps_s1_r <= i_pstate;
            ps_s2_r <= ps_s1_r;
            ps_s3_r <= ps_s2_r;
            if (ps_s2_r == ps_s3_r)
            begin
                pstate_r <= ps_s3_r;
            end
        end
    end

    // pick the word for the accepted power state
    lpcg_gate_sel u_sel
    (
        .i_run_gate(gate_word_r[GW_RUN]),
        .i_sleep_gate(gate_word_r[GW_SLEEP]),
        .i_deep_gate(gate_word_r[GW_DEEP]),
        .i_auto_gate(cfg_r[`LPCG_AUTO_GATE_BIT]),
        .i_pstate(pstate_r),
        .o_gate(gate_sel)
    );

    // enables registered so the clock gate sees a clean level
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_adc_clk_en <= 1'b0;
            o_wdt_clk_en <= 1'b0;
            o_converter_sample_speed <= 4'h0;
        end
        else
        begin
            o_adc_clk_en <= gate_sel[`LPCG_ADC_BIT];
            o_wdt_clk_en <= gate_sel[`LPCG_WDT_BIT];
            // rate code passed through as written; limiting it is software's job
            o_converter_sample_speed <= gate_sel[`LPCG_SPD_MSB:`LPCG_SPD_LSB];
        end
    end

    // accesses to an unclocked unit fault instead of completing
    assign unit_access[`LPCG_IRQ_ADC_FAULT] = i_adc_access;
    assign unit_access[`LPCG_IRQ_WDT_FAULT] = i_wdt_access;
    assign unit_clk_en[`LPCG_IRQ_ADC_FAULT] = o_adc_clk_en;
    assign unit_clk_en[`LPCG_IRQ_WDT_FAULT] = o_wdt_clk_en;
    generate
        for (g = 0; g < UNIT_COUNT; g = g + 1)
        begin : g_fault
            assign fault_ev[g] = unit_access[g] & ~unit_clk_en[g];
        end
    endgenerate

    // fault pulses registered so they stand one full cycle
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_adc_fault <= 1'b0;
            o_wdt_fault <= 1'b0;
        end
        else
        begin
            o_adc_fault <= fault_ev[`LPCG_IRQ_ADC_FAULT];
            o_wdt_fault <= fault_ev[`LPCG_IRQ_WDT_FAULT];
        end
    end

    // sticky status, write one to clear; a new fault wins over the clear
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            irq_stat_r <= 2'h0;
        end
        else if (wr_stat)
        begin
            irq_stat_r <= (irq_stat_r & ~i_wdata[1:0]) | fault_ev;
        end
        else
        begin
            irq_stat_r <= irq_stat_r | fault_ev;
        end
    end

    // interrupt mask, plain read-write
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            irq_mask_r <= 2'h0;
        end
        else if (wr_mask)
        begin
            irq_mask_r <= i_wdata[1:0];
        end
    end

    // read mux; unmapped addresses read zero
    always @*
    begin
        rdata_nxt = 32'h00000000;
        if (addr_hit(i_addr, `LPCG_RUN_OFF))
        begin
            rdata_nxt = gate_word_r[GW_RUN];
        end
        else if (addr_hit(i_addr, `LPCG_SLEEP_OFF))
        begin
            rdata_nxt = gate_word_r[GW_SLEEP];
        end
        else if (addr_hit(i_addr, `LPCG_DEEP_OFF))
        begin
            rdata_nxt = gate_word_r[GW_DEEP];
        end
        else if (addr_hit(i_addr, `LPCG_CFG_OFF))
        begin
            rdata_nxt = cfg_r;
        end
        else if (addr_hit(i_addr, `LPCG_PSTATE_OFF))
        begin
            rdata_nxt = {30'h0, pstate_r};
        end
        else if (addr_hit(i_addr, `LPCG_IRQ_STAT_OFF))
        begin
            rdata_nxt = {30'h0, irq_stat_r};
        end
        else if (addr_hit(i_addr, `LPCG_IRQ_MASK_OFF))
        begin
            rdata_nxt = {30'h0, irq_mask_r};
        end
        else
        begin
            rdata_nxt = 32'h00000000;
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_rdata <= 32'h00000000;
        end
        else
        begin
            o_rdata <= i_rd ? rdata_nxt : 32'h00000000;
        end
    end

    // interrupt level registered so the pin never glitches
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= |(irq_stat_r & irq_mask_r);
        end
    end
endmodule // lpcg_top

// File: lpcg_chk_assertions.sv
// Purpose: port checks for lpcg_top
// Assumes: one clock, async active-low reset
// Notes: bound to every lpcg_top below
`timescale 1ns/1ps
module lpcg_chk
(
    input wire i_clk,
    input wire i_reset_n,
    input wire [11:0] i_addr,
    input wire i_rd,
    input wire [31:0] o_rdata,
    input wire i_adc_access,
    input wire i_wdt_access,
    input wire o_adc_clk_en,
    input wire o_wdt_clk_en,
    input wire [3:0] o_converter_sample_speed,
    input wire o_adc_fault,
    input wire o_wdt_fault
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // read data stands only after a read, reserved bits other than bit 6 of the sleep and deep gating words stay zero
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
    property p_rsv; $past(i_rd) && $past(i_addr) inside {12'h110, 12'h120}
        |-> (o_rdata & 32'hFFFEF0B7) == 32'h0; endproperty
    // a fault answers exactly the accesses made while the clock is off
    property p_adc_f; i_adc_access && !o_adc_clk_en |=> o_adc_fault; endproperty
    property p_wdt_f; i_wdt_access && !o_wdt_clk_en |=> o_wdt_fault; endproperty
    property p_adc_c; o_adc_fault |-> $past(i_adc_access && !o_adc_clk_en); endproperty
    property p_wdt_c; o_wdt_fault |-> $past(i_wdt_access && !o_wdt_clk_en); endproperty
    property p_on; o_adc_clk_en && o_wdt_clk_en |=> !o_adc_fault && !o_wdt_fault; endproperty
    property p_rst; $rose(i_reset_n)
        |-> !o_adc_clk_en && !o_wdt_clk_en && o_converter_sample_speed == 4'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_rsv: assert property (p_rsv) else $error("reserved gating bit read as one");
    a_adc_f: assert property (p_adc_f) else $error("converter fault missing");
    a_wdt_f: assert property (p_wdt_f) else $error("watchdog fault missing");
    a_adc_c: assert property (p_adc_c) else $error("converter fault without cause");
    a_wdt_c: assert property (p_wdt_c) else $error("watchdog fault without cause");
    a_on: assert property (p_on) else $error("fault while clocks on");
    a_rst: assert property (p_rst) else $error("clock on after reset");
    c_fault: cover property (o_adc_fault);
    c_both_on: cover property (o_adc_clk_en && o_wdt_clk_en);
    c_wdt_only: cover property (o_wdt_clk_en && !o_adc_clk_en);
endmodule // lpcg_chk

bind lpcg_top lpcg_chk u_chk (.i_clk, .i_reset_n, .i_addr, .i_rd, .o_rdata, .i_adc_access,
    .i_wdt_access, .o_adc_clk_en, .o_wdt_clk_en, .o_converter_sample_speed, .o_adc_fault,
    .o_wdt_fault);

// File: lpcg_top_tb.sv
// Purpose: self-checking bench for lpcg_top
// Assumes: 50 MHz clock, reset held 5 cycles
// Notes: power state waits cover the 3-flop synchroniser
`timescale 1ns/1ps
module lpcg_top_tb;
    reg i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    reg i_adc_access = 1'b0, i_wdt_access = 1'b0;
    reg [11:0] i_addr = 12'h000;
    reg [31:0] i_wdata = 32'h0;
    reg [1:0] i_pstate = 2'h0;
    wire [31:0] o_rdata;
    wire [3:0] o_converter_sample_speed;
    wire o_adc_clk_en, o_wdt_clk_en, o_adc_fault, o_wdt_fault, o_irq;
    integer n_errors = 0;
    integer compares = 0;
    lpcg_top u_dut (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pstate,
        .i_adc_access, .i_wdt_access, .o_adc_clk_en, .o_wdt_clk_en, .o_converter_sample_speed,
        .o_adc_fault, .o_wdt_fault, .o_irq);
    initial forever #10 i_clk = ~i_clk;
    // four-state compare (!==) so an unknown bit never matches
    task chk(input string what, input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp)
            begin
                n_errors = n_errors + 1;
                $display("mismatch %s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        begin
            @(posedge i_clk);
            i_wr <= 1'b1;
            i_addr <= a;
            i_wdata <= d;
            @(posedge i_clk);
            i_wr <= 1'b0;
        end
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input [11:0] a, input [31:0] exp);
        begin
            @(posedge i_clk);
            i_rd <= 1'b1;
            i_addr <= a;
            @(posedge i_clk);
            i_rd <= 1'b0;
            #1 chk("rdata", o_rdata, exp);
        end
    endtask
    task acc(input w, input exp);
        begin
            @(posedge i_clk);
            i_adc_access <= !w;
            i_wdt_access <= w;
            @(posedge i_clk);
            i_adc_access <= 1'b0;
            i_wdt_access <= 1'b0;
            #1 chk("fault", w ? o_wdt_fault : o_adc_fault, exp);
        end
    endtask
    task ps(input [1:0] s, input [5:0] exp);
        begin
            @(posedge i_clk);
            i_pstate <= s;
            repeat (8) @(posedge i_clk);
            #1 chk("enables", {o_adc_clk_en, o_wdt_clk_en, o_converter_sample_speed}, exp);
        end
    endtask
    task conclude;
        begin
            $display("counts: %0d compares, %0d mismatches", compares, n_errors);
            if (n_errors == 0 && compares > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // cut a hang short long after the sequence should end
    initial
    begin
        #200000;
        n_errors = n_errors + 1;
        conclude;
    end
    initial
    begin
        repeat (5) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(12'h100, 32'h40);
        rd(12'h110, 32'h40);
        rd(12'h120, 32'h40);
        wr(12'h110, 32'hFFFEF2FF);
        rd(12'h110, 32'h208);
        rd(12'h3FC, 32'h0);
        $display("test registers done");
        acc(0, 1);
        rd(12'h140, 32'h1);
        chk("irq", o_irq, 0);
        wr(12'h144, 32'h3);
        repeat (2) @(posedge i_clk);
        #1 chk("irq", o_irq, 1);
        rd(12'h144, 32'h3);
        wr(12'h140, 32'h1);
        repeat (2) @(posedge i_clk);
        #1 chk("irq", o_irq, 0);
        acc(1, 1);
        rd(12'h140, 32'h2);
        $display("test faults done");
        wr(12'h100, 32'h00010108);
        wr(12'h120, 32'h00010000);
        ps(2'h0, 6'h31);
        acc(0, 0);
        acc(1, 0);
        ps(2'h1, 6'h31);
        wr(12'h060, 32'hFFFFFFFF);
        rd(12'h060, 32'h08000000);
        ps(2'h1, 6'h12);
        acc(0, 1);
        ps(2'h2, 6'h20);
        rd(12'h130, 32'h2);
        ps(2'h0, 6'h31);
        $display("test power states done");
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 chk("enables", {o_adc_clk_en, o_wdt_clk_en, o_converter_sample_speed}, 0);
        chk("faults irq", {o_adc_fault, o_wdt_fault, o_irq}, 0);
        chk("rdata", o_rdata, 0);
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd(12'h100, 32'h40);
        $display("test second reset done");
        conclude;
    end
endmodule // lpcg_top_tb
